// ==== logic/adc_sample_ring_formatter.sv ====
`timescale 1ns/1ps
// Behaviour
// - One channel packs consecutively; two channels alternate first-activated then second.
// - Each 12 bit two's complement sample fills one 16 bit word of two bytes.
// - The upper byte of each word is emitted first, the lower byte second.
// - Standard mode: bits 15..12 repeat sample bit 11 as sign extension.
// - Input embedding mode: bits 15..12 carry input lines 3..0.
// - Samples lie in the twelve-bit signed range, never above +2047.
// - Write position wraps to byte zero at the buffer length.
// - Available byte count includes bytes wrapping past the buffer end.
// - A read-only register returns the converter full-scale code.
// - Availability is signalled only once notify-size bytes are ready, minimum one page.
module adc_sample_ring_formatter #(
  parameter int unsigned LEN_WIDTH = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [11:0] ch0_sample,
  input wire logic [11:0] ch1_sample,
  input wire logic sample_valid,
  input wire logic [3:0] multipurpose_input_lines,
  output logic [7:0] byte_data,
  output logic byte_valid,
  output logic [LEN_WIDTH-1:0] byte_address,
  output logic irq
);

  logic [5:0] ctrl_q;
  logic [LEN_WIDTH-1:0] buf_len_q;
  logic [LEN_WIDTH-1:0] notify_q;
  logic [LEN_WIDTH-1:0] avail_len_q;
  logic [LEN_WIDTH-1:0] avail_pos_q;
  logic [LEN_WIDTH-1:0] card_free_q;
  logic [LEN_WIDTH-1:0] wr_pos_q;
  logic [LEN_WIDTH-1:0] pending_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;

  logic ph_valid_q;
  logic ph_write_q;
  logic [31:0] ph_addr_q;
  logic [31:0] rdata_d;

  // Serialiser: up to two words held as four bytes.
  logic [15:0] word_a_q;
  logic [15:0] word_b_q;
  logic [1:0] byte_idx_q;
  logic [1:0] byte_last_q;
  logic busy_q;

  logic run;
  logic two_ch;
  logic [11:0] first_sample;
  logic [11:0] second_sample;
  logic [15:0] word_first;
  logic [15:0] word_second;
  logic take_sample;
  logic [LEN_WIDTH-1:0] words_bytes;
  logic byte_fire;
  logic release_wr;
  logic [LEN_WIDTH-1:0] release_amt;
  logic notify_hit;
  logic [LEN_WIDTH-1:0] pos_sum;
  logic [LEN_WIDTH-1:0] next_wr;
  logic [LEN_WIDTH-1:0] pending_next;
  logic reg_wr;
  logic acct_restart;
  logic overrun_hit;
  logic [1:0] irq_clear;
  logic [1:0] irq_set;

  sample_word_if first_if ();
  sample_word_if second_if ();

  assign run = ctrl_q[ring_fmt_pkg::CTRL_RUN_BIT];
  assign two_ch = ctrl_q[ring_fmt_pkg::CTRL_CH0_BIT] & ctrl_q[ring_fmt_pkg::CTRL_CH1_BIT];

  // The first-activated channel leads; software names it in the control word.
  always_comb
  begin
    if (two_ch)
    begin
      first_sample = ctrl_q[ring_fmt_pkg::CTRL_FIRST_BIT] ? ch1_sample : ch0_sample;
      second_sample = ctrl_q[ring_fmt_pkg::CTRL_FIRST_BIT] ? ch0_sample : ch1_sample;
    end
    else
    begin
      first_sample = ctrl_q[ring_fmt_pkg::CTRL_CH1_BIT] ? ch1_sample : ch0_sample;
      second_sample = ch1_sample;
    end
  end

  assign first_if.sample = first_sample;
  assign first_if.digin = multipurpose_input_lines;
  assign first_if.digin_mode = ctrl_q[ring_fmt_pkg::CTRL_DIGIN_BIT];
  assign word_first = first_if.word;
  assign second_if.sample = second_sample;
  assign second_if.digin = multipurpose_input_lines;
  assign second_if.digin_mode = ctrl_q[ring_fmt_pkg::CTRL_DIGIN_BIT];
  assign word_second = second_if.word;

  sample_word_pack first_pack (
    .port(first_if.packer)
  );

  sample_word_pack second_pack (
    .port(second_if.packer)
  );

  assign words_bytes = two_ch ? LEN_WIDTH'(4) : LEN_WIDTH'(2);
  // A sample set is taken only when a whole set of words fits in card space.
  // Generation mode only stops capture here; replay toward the converter lives outside this block.
  assign take_sample = run && sample_valid && !busy_q && (card_free_q >= words_bytes)
                       && !ctrl_q[ring_fmt_pkg::CTRL_GEN_BIT];
  assign byte_fire = busy_q;

  // One decode of the data-phase write keeps every writable register on the same address map.
  assign reg_wr = ph_valid_q && ph_write_q && (ph_addr_q[31:12] == 20'h00000);

  // AHB-Lite slave: single-cycle data phase, always OKAY.
  // Writes land at the end of the data phase, so a read straight after a write sees the new value.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q <= 32'h0000_0000;
    end
    else if (hready)
    begin
      ph_valid_q <= hsel && htrans[1];
      ph_write_q <= hwrite;
      ph_addr_q <= haddr;
    end
  end

  assign release_wr = reg_wr && (ph_addr_q[11:0] == ring_fmt_pkg::ADDR_RELEASE);
  // Release is clamped to what the host holds, so a runaway count cannot hand the card unread bytes.
  assign release_amt = (hwdata[LEN_WIDTH-1:0] > avail_len_q) ? avail_len_q : hwdata[LEN_WIDTH-1:0];

  // Ring arithmetic keeps offsets below the buffer length.
  // One subtraction is enough because a release never exceeds the buffer length.
  always_comb
  begin
    pos_sum = avail_pos_q + release_amt;
    if (pos_sum >= buf_len_q)
    begin
      pos_sum = pos_sum - buf_len_q;
    end
    next_wr = wr_pos_q + LEN_WIDTH'(1);
    if (next_wr >= buf_len_q)
    begin
      next_wr = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_q <= 6'h01 << ring_fmt_pkg::CTRL_CH0_BIT;
      buf_len_q <= LEN_WIDTH'(ring_fmt_pkg::BUF_LEN_RESET);
      notify_q <= LEN_WIDTH'(ring_fmt_pkg::NOTIFY_RESET);
      irq_mask_q <= 2'h0;
    end
    else if (reg_wr)
    begin
      unique case (ph_addr_q[11:0])
        ring_fmt_pkg::ADDR_CONTROL: ctrl_q <= hwdata[5:0];
        ring_fmt_pkg::ADDR_BUF_LEN: if (!run) buf_len_q <= hwdata[LEN_WIDTH-1:0];
        ring_fmt_pkg::ADDR_NOTIFY:
        begin
          // Granularity below one page is clamped to a page.
          notify_q <= (hwdata < ring_fmt_pkg::NOTIFY_MIN) ? LEN_WIDTH'(ring_fmt_pkg::NOTIFY_MIN)
                      : hwdata[LEN_WIDTH-1:0];
        end
        ring_fmt_pkg::ADDR_IRQ_MASK: irq_mask_q <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Accounting of the byte ring, shared between host and card.
  always_comb
  begin
    pending_next = pending_q + (byte_fire ? LEN_WIDTH'(1) : LEN_WIDTH'(0));
  end
  assign notify_hit = pending_next >= notify_q;

  // A new buffer length hands the whole ring back to the card, so it is only taken while stopped.
  assign acct_restart = reg_wr && (ph_addr_q[11:0] == ring_fmt_pkg::ADDR_BUF_LEN) && !run;

  always_ff @(posedge clock)
  begin
    if (reset || acct_restart)
    begin
      avail_len_q <= '0;
      avail_pos_q <= '0;
      pending_q <= '0;
      card_free_q <= reset ? LEN_WIDTH'(ring_fmt_pkg::BUF_LEN_RESET) : hwdata[LEN_WIDTH-1:0];
    end
    else
    begin
      // Bytes become visible to the host only in notify-size steps.
      if (notify_hit)
      begin
        pending_q <= '0;
      end
      else
      begin
        pending_q <= pending_next;
      end
      // The count spans the wrap, so it is simply total bytes owned by host.
      avail_len_q <= avail_len_q + (notify_hit ? pending_next : '0)
                     - (release_wr ? release_amt : '0);
      if (release_wr)
      begin
        avail_pos_q <= pos_sum;
      end
      card_free_q <= card_free_q + (release_wr ? release_amt : '0)
                     - (take_sample ? words_bytes : '0);
    end
  end

  // Serialiser emits upper byte first, then lower, per word.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      byte_idx_q <= 2'h0;
      byte_last_q <= 2'h0;
      word_a_q <= 16'h0000;
      word_b_q <= 16'h0000;
      byte_data <= 8'h00;
      byte_valid <= 1'b0;
      byte_address <= '0;
      wr_pos_q <= '0;
    end
    else
    begin
      byte_valid <= byte_fire;
      // A set is never taken while bytes go out, so both held words stay put for the whole burst.
      if (take_sample)
      begin
        word_a_q <= word_first;
        word_b_q <= word_second;
        byte_idx_q <= 2'h0;
        byte_last_q <= two_ch ? 2'h3 : 2'h1;
        busy_q <= 1'b1;
      end
      else if (byte_fire)
      begin
        byte_idx_q <= byte_idx_q + 2'h1;
        busy_q <= byte_idx_q != byte_last_q;
      end
      if (byte_fire)
      begin
        unique case (byte_idx_q)
          2'h0: byte_data <= word_a_q[15:8];
          2'h1: byte_data <= word_a_q[7:0];
          2'h2: byte_data <= word_b_q[15:8];
          2'h3: byte_data <= word_b_q[7:0];
        endcase
        byte_address <= wr_pos_q;
        wr_pos_q <= next_wr;
      end
      // Restarting the ring puts the card back at byte zero, where the host expects it.
      if (acct_restart)
      begin
        wr_pos_q <= '0;
      end
    end
  end

  // A set offered while the card has too little room is lost, and software must hear of it.
  assign overrun_hit = run && sample_valid && !busy_q && (card_free_q < words_bytes)
                       && !ctrl_q[ring_fmt_pkg::CTRL_GEN_BIT];
  assign irq_clear = (reg_wr && ph_addr_q[11:0] == ring_fmt_pkg::ADDR_IRQ_STATUS) ? hwdata[1:0] : 2'h0;
  assign irq_set[ring_fmt_pkg::IRQ_NOTIFY_BIT] = notify_hit;
  assign irq_set[ring_fmt_pkg::IRQ_OVERRUN_BIT] = overrun_hit;

  // Sticky events; a new event wins over a clearing write.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_status_q <= 2'h0;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_set;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // The full-scale word sits above the small register window, so it is decoded first.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (ph_addr_q[31:14] == 18'h00000 && ph_addr_q[13:0] == ring_fmt_pkg::ADDR_FULL_SCALE)
    begin
      rdata_d = ring_fmt_pkg::FULL_SCALE_VALUE;
    end
    else if (ph_addr_q[31:12] == 20'h00000)
    begin
      unique case (ph_addr_q[11:0])
        ring_fmt_pkg::ADDR_CONTROL: rdata_d = {26'h0, ctrl_q};
        ring_fmt_pkg::ADDR_BUF_LEN: rdata_d = 32'(buf_len_q);
        ring_fmt_pkg::ADDR_NOTIFY: rdata_d = 32'(notify_q);
        ring_fmt_pkg::ADDR_AVAIL_LEN: rdata_d = 32'(avail_len_q);
        ring_fmt_pkg::ADDR_AVAIL_POS: rdata_d = 32'(avail_pos_q);
        ring_fmt_pkg::ADDR_RELEASE: rdata_d = 32'(card_free_q);
        ring_fmt_pkg::ADDR_IRQ_STATUS: rdata_d = {30'h0, irq_status_q};
        ring_fmt_pkg::ADDR_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
        ring_fmt_pkg::ADDR_WR_POS: rdata_d = 32'(wr_pos_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data is combinational from the latched address phase, in the data phase.
  assign hrdata = (ph_valid_q && !ph_write_q) ? rdata_d : 32'h0000_0000;

endmodule : adc_sample_ring_formatter

// ==== logic/ring_fmt_pkg.sv ====
package ring_fmt_pkg;

  // Register byte addresses (word aligned).
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_BUF_LEN = 12'h004;
  localparam logic [11:0] ADDR_NOTIFY = 12'h008;
  localparam logic [11:0] ADDR_AVAIL_LEN = 12'h00c;
  localparam logic [11:0] ADDR_AVAIL_POS = 12'h010;
  localparam logic [11:0] ADDR_RELEASE = 12'h014;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h018;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h01c;
  localparam logic [11:0] ADDR_WR_POS = 12'h020;
  // The printed offset 0x466 is not a multiple of four, so it is an index.
  localparam logic [11:0] IDX_FULL_SCALE = 12'h466;
  localparam logic [13:0] ADDR_FULL_SCALE = {IDX_FULL_SCALE, 2'b00};

  // Control register fields.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_DIGIN_BIT = 1;
  localparam int CTRL_CH0_BIT = 2;
  localparam int CTRL_CH1_BIT = 3;
  localparam int CTRL_FIRST_BIT = 4;
  localparam int CTRL_GEN_BIT = 5;

  // Interrupt status fields.
  localparam int IRQ_NOTIFY_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_WIDTH = 2;

  // Reset values and fixed constants.
  localparam logic [31:0] FULL_SCALE_VALUE = 32'h0000_0800;
  localparam logic [31:0] BUF_LEN_RESET = 32'h0001_0000;
  localparam logic [31:0] NOTIFY_RESET = 32'h0000_1000;
  localparam logic [31:0] NOTIFY_MIN = 32'h0000_1000;

  localparam int SAMPLE_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam int DIGIN_BITS = 4;

endpackage : ring_fmt_pkg

// ==== logic/sample_word_if.sv ====
`timescale 1ns/1ps
interface sample_word_if;
  logic [11:0] sample;
  logic [3:0] digin;
  logic digin_mode;
  logic [15:0] word;
  modport packer (input sample, input digin, input digin_mode, output word);
  modport user (output sample, output digin, output digin_mode, input word);
endinterface : sample_word_if

// ==== logic/sample_word_pack.sv ====
`timescale 1ns/1ps
module sample_word_pack (
  sample_word_if.packer port
);

  // Top nibble is either sign extension or the four input lines.
  always_comb
  begin
    port.word[11:0] = port.sample;
    if (port.digin_mode)
    begin
      port.word[15:12] = port.digin;
    end
    else
    begin
      port.word[15:12] = {4{port.sample[11]}};
    end
  end

endmodule : sample_word_pack

// ==== testbench/host_buffer_model.sv ====
`timescale 1ns/1ps
module host_buffer_model (
  input wire logic clock,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [31:0] byte_address
);
  logic [7:0] mem [0:4095];

  always @(posedge clock)
    if (byte_valid)
      mem[byte_address[11:0]] <= byte_data;

  function automatic logic [15:0] word_at(input int a);
    return {mem[a], mem[a + 1]};
  endfunction : word_at

  // Embedded lines must go before the word is used as a signed value.
  function automatic logic [15:0] as_sample(input logic [15:0] w);
    return {{4{w[11]}}, w[11:0]};
  endfunction : as_sample
endmodule : host_buffer_model

// ==== testbench/ring_fmt_asserts.sv ====
`timescale 1ns/1ps
module ring_fmt_asserts #(
  parameter int unsigned LEN_WIDTH = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input wire logic [11:0] ch0_sample,
  input wire logic [11:0] ch1_sample,
  input logic [7:0] byte_data,
  input logic byte_valid,
  input logic [LEN_WIDTH-1:0] byte_address,
  input logic irq
);
  logic rd_q, wr_q;
  logic [31:0] a_q;
  logic [1:0] mask_q;

  always_ff @(posedge clock)
    if (reset)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      mask_q <= 2'b00;
    end
    else
    begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        a_q <= haddr;
      if (wr_q && a_q == {20'h0, ring_fmt_pkg::ADDR_IRQ_MASK})
        mask_q <= hwdata[1:0];
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_hrdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside read phase");
  a_full_scale: assert property (rd_q && a_q == {18'h0, ring_fmt_pkg::ADDR_FULL_SCALE}
    |-> hrdata == ring_fmt_pkg::FULL_SCALE_VALUE) else $error("full scale value wrong");
  a_word_pair: assert property (byte_valid && !$past(byte_valid)
    |=> byte_valid && byte_address == $past(byte_address) + 1) else $error("word bytes not paired");
  a_ring_step: assert property (byte_valid && $past(byte_valid)
    |-> byte_address == $past(byte_address) + 1 || byte_address == 0) else $error("byte address step wrong");
  a_burst_len: assert property (byte_valid [*4] |=> !byte_valid) else $error("burst too long");
  a_high_first: assert property (byte_valid && !$past(byte_valid) |->
    byte_data[3:0] == $past(ch0_sample[11:8], 2) || byte_data[3:0] == $past(ch1_sample[11:8], 2))
    else $error("high byte not first");
  a_low_second: assert property (byte_valid && !$past(byte_valid) |=>
    byte_data == $past(ch0_sample[7:0], 3) || byte_data == $past(ch1_sample[7:0], 3))
    else $error("low byte not second");
  a_irq_masked: assert property (mask_q == 2'b00 |-> !irq) else $error("interrupt while masked");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !byte_valid && !irq) else $error("busy after reset");

  c_two_words: cover property (byte_valid [*4]);
  c_scale_read: cover property (rd_q && a_q == {18'h0, ring_fmt_pkg::ADDR_FULL_SCALE});
  c_irq_up: cover property ($rose(irq));
endmodule : ring_fmt_asserts

bind adc_sample_ring_formatter ring_fmt_asserts #(.LEN_WIDTH(LEN_WIDTH)) chk (.*);

// ==== testbench/adc_sample_ring_formatter_tb_top.sv ====
`timescale 1ns/1ps
module adc_sample_ring_formatter_tb_top;
  logic clock = 0, reset = 1, hwrite = 0, sample_valid = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, x = 50, byte_address;
  logic [11:0] s0 = 0, s1 = 0;
  logic [3:0] lines = 0;
  logic [7:0] byte_data;
  logic hreadyout, hresp, byte_valid, irq;
  int fails = 0, checks = 0, wp = 0;

  always #2.5 clock = ~clock;

  adc_sample_ring_formatter dut (.clock(clock), .reset(reset), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch0_sample(s0), .ch1_sample(s1), .sample_valid(sample_valid),
    .multipurpose_input_lines(lines), .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_address(byte_address), .irq(irq));
  host_buffer_model rdm (.clock(clock), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_address(byte_address));

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic ahb(input logic w, input logic [13:0] a, input logic [31:0] d);
    haddr <= {18'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  function automatic logic [15:0] exp_word(input logic [11:0] s, input logic [3:0] l, input logic emb);
    return {emb ? l : {4{s[11]}}, s};
  endfunction : exp_word

  // Sets are spaced two cycles wider than the minimum, so none is dropped as busy and the model
  // has stored the last byte of a set before the bench reads it back.
  task automatic feed(input int n, input int nch, input logic emb, input logic b1st, input logic look);
    logic [11:0] a, b;
    logic [15:0] w;
    for (int i = 0; i < n; i++)
    begin
      x = xs(x);
      a = (i == 0) ? 12'h800 : x[11:0];
      b = (i == 0) ? 12'h7ff : x[23:12];
      s0 <= a;
      s1 <= b;
      lines <= x[27:24];
      sample_valid <= 1'b1;
      @(posedge clock);
      sample_valid <= 1'b0;
      repeat (2 * nch + 2) @(posedge clock);
      if (look)
      begin
        if (b1st) {a, b} = {b, a};
        w = rdm.word_at(wp);
        chk("first_word", w, exp_word(a, x[27:24], emb));
        chk("signed_value", rdm.as_sample(w), {{4{a[11]}}, a});
        if (nch == 2) chk("second_word", rdm.word_at(wp + 2), exp_word(b, x[27:24], emb));
        wp = (wp + 2 * nch) % 4096;
      end
    end
  endtask : feed

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    test_done;
  end

  initial
  begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    ahb(1, ring_fmt_pkg::ADDR_IRQ_MASK, 0);
    ahb(0, ring_fmt_pkg::ADDR_FULL_SCALE, 0);
    chk("full_scale", rd, ring_fmt_pkg::FULL_SCALE_VALUE);
    ahb(0, 14'h0ffc, 0);
    chk("unmapped", rd, 32'h0);
    ahb(0, ring_fmt_pkg::ADDR_BUF_LEN, 0);
    chk("buf_len", rd, ring_fmt_pkg::BUF_LEN_RESET);
    ahb(1, ring_fmt_pkg::ADDR_BUF_LEN, 32'h1000);
    ahb(1, ring_fmt_pkg::ADDR_NOTIFY, 32'h10);
    ahb(0, ring_fmt_pkg::ADDR_NOTIFY, 0);
    chk("notify", rd, ring_fmt_pkg::NOTIFY_MIN);
    ahb(1, ring_fmt_pkg::ADDR_CONTROL, 32'h5);
    feed(2047, 1, 0, 0, 1);
    ahb(0, ring_fmt_pkg::ADDR_IRQ_STATUS, 0);
    chk("notify_early", rd, 32'h0);
    feed(1, 1, 0, 0, 1);
    ahb(0, ring_fmt_pkg::ADDR_IRQ_STATUS, 0);
    chk("notify_set", rd, 32'h1);
    ahb(0, ring_fmt_pkg::ADDR_AVAIL_LEN, 0);
    chk("avail_full", rd, 32'h1000);
    ahb(0, ring_fmt_pkg::ADDR_WR_POS, 0);
    chk("wrap_pos", rd, 32'h0);
    feed(1, 1, 0, 0, 0);
    ahb(0, ring_fmt_pkg::ADDR_IRQ_STATUS, 0);
    chk("overrun", rd, 32'h3);
    chk("irq_masked", irq, 1'b0);
    // The interrupt level follows the registers combinationally, from the edge that ends the data phase.
    ahb(1, ring_fmt_pkg::ADDR_IRQ_MASK, 32'h2);
    @(posedge clock);
    chk("irq_up", irq, 1'b1);
    ahb(1, ring_fmt_pkg::ADDR_IRQ_STATUS, 32'h2);
    @(posedge clock);
    chk("irq_cleared", irq, 1'b0);
    ahb(1, ring_fmt_pkg::ADDR_RELEASE, 32'h800);
    ahb(0, ring_fmt_pkg::ADDR_AVAIL_POS, 0);
    chk("pos_moved", rd, 32'h800);
    ahb(0, ring_fmt_pkg::ADDR_RELEASE, 0);
    chk("free", rd, 32'h800);
    ahb(1, ring_fmt_pkg::ADDR_CONTROL, 32'h1f);
    feed(512, 2, 1, 1, 1);
    ahb(0, ring_fmt_pkg::ADDR_AVAIL_LEN, 0);
    // The new half has not yet made a notify step, so the host still owns only the older half.
    chk("avail_held", rd, 32'h800);
    ahb(1, ring_fmt_pkg::ADDR_RELEASE, 32'h1000);
    ahb(0, ring_fmt_pkg::ADDR_AVAIL_POS, 0);
    chk("pos_wrapped", rd, 32'h0);
    ahb(0, ring_fmt_pkg::ADDR_AVAIL_LEN, 0);
    chk("avail_released", rd, 32'h0);
    ahb(1, ring_fmt_pkg::ADDR_CONTROL, 32'h24);
    ahb(1, ring_fmt_pkg::ADDR_BUF_LEN, 32'h1000);
    ahb(0, ring_fmt_pkg::ADDR_RELEASE, 0);
    chk("gen_free", rd, 32'h1000);
    ahb(1, ring_fmt_pkg::ADDR_CONTROL, 32'h25);
    feed(1, 1, 0, 0, 0);
    ahb(0, ring_fmt_pkg::ADDR_WR_POS, 0);
    chk("gen_no_capture", rd, 32'h0);
    test_done;
  end
endmodule : adc_sample_ring_formatter_tb_top
